// file: mcuid_pkg.sv
// Constants and types shared by the instruction decoder files
package mcuid_pkg;

  // Instruction word and opcode fields
  localparam int unsigned WORD_W  = 14;
  localparam logic [5:0]  OPC_ADD_WITH_CARRY = 6'h3d;
  localparam logic [5:0]  OPC_ARITH_SHR      = 6'h37;
  localparam logic [5:0]  OPC_OR_REG_FILE    = 6'h04;
  localparam logic [5:0]  OPC_ROT_LEFT       = 6'h0d;
  localparam logic [5:0]  OPC_ROT_RIGHT      = 6'h0c;
  localparam logic [5:0]  OPC_OR_LITERAL     = 6'h38;
  localparam logic [5:0]  OPC_XOR_LITERAL    = 6'h3a;
  localparam logic [5:0]  OPC_SUB_LITERAL    = 6'h3c;
  localparam logic [5:0]  OPC_LOAD_PCH       = 6'h31;
  localparam logic [3:0]  OPC_SKIP_CLEAR     = 4'h6;
  localparam logic [3:0]  OPC_SKIP_SET       = 4'h7;

  // Field positions
  localparam int unsigned OPC_HI   = 13;
  localparam int unsigned OPC_LO   = 8;
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned BIT_LO   = 7;
  localparam int unsigned LIT_HI   = 7;

  // Special file addresses
  localparam logic [6:0] IND0_ADDR = 7'h00;
  localparam logic [6:0] IND1_ADDR = 7'h01;
  localparam logic [6:0] PCL_ADDR  = 7'h02;
  localparam int unsigned NUM_IND  = 2;

  // Instruction period in oscillator periods
  localparam int unsigned  QUARTER_COUNT = 4;
  localparam logic [1:0]   PHASE_LAST    = 2'(QUARTER_COUNT - 1);
  localparam logic [1:0]   ONE_CYCLE     = 2'h1;

  // Register offsets and reset values
  localparam logic [3:0] CTRL_OFS    = 4'h0;
  localparam logic [3:0] FSRMSB_OFS  = 4'h1;
  localparam logic [3:0] STATUS_OFS  = 4'h2;
  localparam logic [3:0] LASTOP_OFS  = 4'h3;
  localparam logic [7:0] CTRL_RST    = 8'h01;
  localparam logic [1:0] FSRMSB_RST  = 2'h0;

  typedef enum logic [3:0] {
    OP_NONE,
    ADD_WITH_CARRY_OP,
    ARITH_SHIFT_RIGHT_OP,
    OR_REG_WITH_FILE_OP,
    ROTATE_LEFT_CARRY_OP,
    ROTATE_RIGHT_CARRY_OP,
    TEST_BIT_SKIP_CLEAR_OP,
    TEST_BIT_SKIP_SET_OP,
    OR_LITERAL_OP,
    XOR_LITERAL_OP,
    LOAD_PC_HIGH_LATCH_OP,
    SUBTRACT_FROM_LITERAL_OP
  } mcuid_op_t;

  typedef struct packed {
    mcuid_op_t  op;
    logic       dest_file;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [7:0] literal;
    logic       upd_carry;
    logic       upd_digit_carry;
    logic       upd_zero;
  } mcuid_dec_t;

endpackage : mcuid_pkg

// file: mcuid_phase_gen.sv
// Quarter-rate instruction period generator
`timescale 1ns/1ps
`default_nettype none
module mcuid_phase_gen
  import mcuid_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  output var  logic [1:0] phase_reg,
  output var  logic       period_strobe_reg
);

  logic [1:0] phase_next;

  assign phase_next = (phase_reg == PHASE_LAST) ? 2'h0 : phase_reg + 2'h1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // One strobe per four oscillator periods
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      period_strobe_reg <= 1'b0;
    end else begin
      period_strobe_reg <= (phase_next == PHASE_LAST);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_period_four_osc: assert property (
    period_strobe_reg |=> !period_strobe_reg [*3] ##1 period_strobe_reg)
    else $error("Instruction period is not four oscillator periods");

endmodule : mcuid_phase_gen
`default_nettype wire

// file: mcuid_decoder.sv
// Instruction decoder with cycle accounting and register port
//
// Behaviour
// - Add-with-carry updates carry, digit carry, zero.
// - Arithmetic right shift updates carry and zero.
// - OR working with file updates zero only.
// - Rotate left through carry updates carry only.
// - Rotate right through carry updates carry only.
// - Test bit, skip when clear, two cycles.
// - Test bit, skip when set, two cycles.
// - OR literal into working, zero only.
// - XOR literal into working, zero only.
// - Load 7-bit literal into PC high latch.
// - Literal minus working updates three flags.
// - PC change or true test costs two.
// - Indirect access with select MSB adds cycle.
// - Instruction period equals four oscillator periods.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mcuid_decoder
  import mcuid_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [WORD_W-1:0] instr_word,
  input  wire logic              instr_valid,
  input  wire logic              file_bit_value,
  output var  logic              instr_ready_reg,
  output var  logic              dec_valid_reg,
  output var  mcuid_dec_t        dec_reg,
  output var  logic [1:0]        cycles_reg,
  output var  logic              skip_reg,
  output var  logic              indirect_reg,
  output var  logic [1:0]        phase_reg,
  output var  logic              period_strobe_reg,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [7:0]        reg_rdata_reg
);

  // Indirect register match for one address
  function automatic logic ind_hit(input logic [6:0] addr,
                                   input logic [6:0] ind_addr,
                                   input logic       msb);
    ind_hit = (addr == ind_addr) && msb;
  endfunction : ind_hit

  logic [7:0]   ctrl_reg;
  logic [1:0]   sel_msb_reg;
  mcuid_dec_t   dec_next;
  logic         byte_op;
  logic         bit_op;
  logic         skip_next;
  logic         pc_write;
  logic         indirect_next;
  logic [1:0]   cycles_next;
  logic [1:0]   remain_reg;
  logic [1:0]   remain_next;
  logic         take;
  logic [6:0]   addr_f;
  logic [NUM_IND-1:0] ind_vec;
  logic [NUM_IND*7-1:0] ind_addrs;

  assign ind_addrs = {IND1_ADDR, IND0_ADDR};
  assign addr_f    = instr_word[6:0];

  mcuid_phase_gen u_phase (
    .clk               (clk),
    .nrst              (nrst),
    .phase_reg         (phase_reg),
    .period_strobe_reg (period_strobe_reg)
  );

  // Instructions are taken at the end of an instruction period
  assign take = instr_valid && instr_ready_reg && period_strobe_reg && ctrl_reg[0];

  always_comb begin
    dec_next           = '0;
    dec_next.op        = OP_NONE;
    dec_next.file_addr = addr_f;
    dec_next.bit_sel   = instr_word[9:BIT_LO];
    dec_next.literal   = instr_word[LIT_HI:0];
    byte_op            = 1'b0;
    bit_op             = 1'b0;
    case (instr_word[OPC_HI:OPC_LO])
      OPC_ADD_WITH_CARRY: begin
        dec_next.op              = ADD_WITH_CARRY_OP;
        dec_next.upd_carry       = 1'b1;
        dec_next.upd_digit_carry = 1'b1;
        dec_next.upd_zero        = 1'b1;
        byte_op                  = 1'b1;
      end
      OPC_ARITH_SHR: begin
        dec_next.op        = ARITH_SHIFT_RIGHT_OP;
        dec_next.upd_carry = 1'b1;
        dec_next.upd_zero  = 1'b1;
        byte_op            = 1'b1;
      end
      OPC_OR_REG_FILE: begin
        dec_next.op       = OR_REG_WITH_FILE_OP;
        dec_next.upd_zero = 1'b1;
        byte_op           = 1'b1;
      end
      OPC_ROT_LEFT: begin
        dec_next.op        = ROTATE_LEFT_CARRY_OP;
        dec_next.upd_carry = 1'b1;
        byte_op            = 1'b1;
      end
      OPC_ROT_RIGHT: begin
        dec_next.op        = ROTATE_RIGHT_CARRY_OP;
        dec_next.upd_carry = 1'b1;
        byte_op            = 1'b1;
      end
      OPC_OR_LITERAL: begin
        dec_next.op       = OR_LITERAL_OP;
        dec_next.upd_zero = 1'b1;
      end
      OPC_XOR_LITERAL: begin
        dec_next.op       = XOR_LITERAL_OP;
        dec_next.upd_zero = 1'b1;
      end
      OPC_SUB_LITERAL: begin
        dec_next.op              = SUBTRACT_FROM_LITERAL_OP;
        dec_next.upd_carry       = 1'b1;
        dec_next.upd_digit_carry = 1'b1;
        dec_next.upd_zero        = 1'b1;
      end
      OPC_LOAD_PCH: begin
        if (instr_word[DEST_POS]) begin
          dec_next.op      = LOAD_PC_HIGH_LATCH_OP;
          dec_next.literal = {1'b0, instr_word[6:0]};
        end
      end
      default: begin
        if (instr_word[OPC_HI:10] == OPC_SKIP_CLEAR) begin
          dec_next.op = TEST_BIT_SKIP_CLEAR_OP;
          bit_op      = 1'b1;
        end else if (instr_word[OPC_HI:10] == OPC_SKIP_SET) begin
          dec_next.op = TEST_BIT_SKIP_SET_OP;
          bit_op      = 1'b1;
        end
      end
    endcase
    // Destination only has meaning for byte file operations
    dec_next.dest_file = byte_op && instr_word[DEST_POS];
  end

  // Skip when the tested bit matches the skip sense
  assign skip_next = (dec_next.op == TEST_BIT_SKIP_CLEAR_OP && !file_bit_value)
                  || (dec_next.op == TEST_BIT_SKIP_SET_OP && file_bit_value);

  // Writing the low program counter byte changes the flow
  assign pc_write = dec_next.dest_file && (addr_f == PCL_ADDR);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IND; gi++) begin : g_ind
      assign ind_vec[gi] = ind_hit(addr_f, ind_addrs[gi*7 +: 7], sel_msb_reg[gi]);
    end
  endgenerate

  assign indirect_next = (byte_op || bit_op) && (|ind_vec);

  // Base cycle, second cycle as no-op, indirect extra cycle
  assign cycles_next = ONE_CYCLE
                     + {1'b0, skip_next || pc_write}
                     + {1'b0, indirect_next};

  always_comb begin
    remain_next = remain_reg;
    if (take) begin
      remain_next = cycles_next - ONE_CYCLE;
    end else if (period_strobe_reg && remain_reg != 2'h0) begin
      remain_next = remain_reg - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remain_reg      <= 2'h0;
      instr_ready_reg <= 1'b1;
    end else begin
      remain_reg      <= remain_next;
      instr_ready_reg <= (remain_next == 2'h0);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_reg      <= '0;
      cycles_reg   <= 2'h0;
      skip_reg     <= 1'b0;
      indirect_reg <= 1'b0;
    end else if (take) begin
      dec_reg      <= dec_next;
      cycles_reg   <= cycles_next;
      skip_reg     <= skip_next;
      indirect_reg <= indirect_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_valid_reg <= 1'b0;
    end else begin
      dec_valid_reg <= take;
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg    <= CTRL_RST;
      sel_msb_reg <= FSRMSB_RST;
    end else if (reg_wr) begin
      if (reg_addr == CTRL_OFS) begin
        ctrl_reg <= {7'h00, reg_wdata[0]};
      end
      if (reg_addr == FSRMSB_OFS) begin
        sel_msb_reg <= reg_wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        CTRL_OFS:   reg_rdata_reg <= ctrl_reg;
        FSRMSB_OFS: reg_rdata_reg <= {6'h00, sel_msb_reg};
        STATUS_OFS: reg_rdata_reg <= {3'h0, indirect_reg, skip_reg, cycles_reg,
                                      !instr_ready_reg};
        LASTOP_OFS: reg_rdata_reg <= {4'h0, dec_reg.op};
        default:    reg_rdata_reg <= 8'h00;
      endcase
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_take_opc(logic [5:0] opc);
    take && instr_word[OPC_HI:OPC_LO] == opc;
  endsequence

  sequence s_take_plain;
    take && !indirect_next;
  endsequence

  a_add_carry_flags: assert property (
    s_take_opc(OPC_ADD_WITH_CARRY) and s_take_plain |=> dec_valid_reg
    && dec_reg.op == ADD_WITH_CARRY_OP && dec_reg.upd_carry
    && dec_reg.upd_digit_carry && dec_reg.upd_zero
    && cycles_reg == 2'h1 + {1'b0, $past(pc_write)})
    else $error("Add with carry decoded wrongly");

  a_asr_flags: assert property (
    s_take_opc(OPC_ARITH_SHR) |=> dec_reg.op == ARITH_SHIFT_RIGHT_OP
    && dec_reg.upd_carry && !dec_reg.upd_digit_carry && dec_reg.upd_zero)
    else $error("Arithmetic shift decoded wrongly");

  a_or_file_flags: assert property (
    s_take_opc(OPC_OR_REG_FILE) |=> dec_reg.op == OR_REG_WITH_FILE_OP
    && !dec_reg.upd_carry && !dec_reg.upd_digit_carry && dec_reg.upd_zero)
    else $error("OR with file decoded wrongly");

  a_rot_left_flags: assert property (
    s_take_opc(OPC_ROT_LEFT) |=> dec_reg.op == ROTATE_LEFT_CARRY_OP
    && dec_reg.upd_carry && !dec_reg.upd_digit_carry && !dec_reg.upd_zero)
    else $error("Rotate left decoded wrongly");

  a_rot_right_flags: assert property (
    s_take_opc(OPC_ROT_RIGHT) |=> dec_reg.op == ROTATE_RIGHT_CARRY_OP
    && dec_reg.upd_carry && !dec_reg.upd_digit_carry && !dec_reg.upd_zero)
    else $error("Rotate right decoded wrongly");

  a_skip_clear_cycles: assert property (
    take && instr_word[OPC_HI:10] == OPC_SKIP_CLEAR && !indirect_next
    |=> cycles_reg == ($past(file_bit_value) ? 2'h1 : 2'h2))
    else $error("Skip-if-clear cycle count wrong");

  a_skip_set_cycles: assert property (
    take && instr_word[OPC_HI:10] == OPC_SKIP_SET && !indirect_next
    |=> cycles_reg == ($past(file_bit_value) ? 2'h2 : 2'h1))
    else $error("Skip-if-set cycle count wrong");

  a_or_lit_flags: assert property (
    s_take_opc(OPC_OR_LITERAL) |=> dec_reg.op == OR_LITERAL_OP
    && dec_reg.literal == $past(instr_word[7:0]) && dec_reg.upd_zero
    && !dec_reg.upd_carry && !dec_reg.dest_file && cycles_reg == 2'h1)
    else $error("OR literal decoded wrongly");

  a_xor_lit_flags: assert property (
    s_take_opc(OPC_XOR_LITERAL) |=> dec_reg.op == XOR_LITERAL_OP
    && dec_reg.upd_zero && !dec_reg.upd_carry && cycles_reg == 2'h1)
    else $error("XOR literal decoded wrongly");

  a_load_pch_lit: assert property (
    s_take_opc(OPC_LOAD_PCH) && instr_word[DEST_POS]
    |=> dec_reg.op == LOAD_PC_HIGH_LATCH_OP
    && dec_reg.literal == {1'b0, $past(instr_word[6:0])}
    && !dec_reg.upd_zero && !dec_reg.upd_carry && cycles_reg == 2'h1)
    else $error("PC high latch load decoded wrongly");

  a_sub_lit_flags: assert property (
    s_take_opc(OPC_SUB_LITERAL) |=> dec_reg.op == SUBTRACT_FROM_LITERAL_OP
    && dec_reg.upd_carry && dec_reg.upd_digit_carry && dec_reg.upd_zero)
    else $error("Subtract from literal decoded wrongly");

  a_two_cycle_busy: assert property (
    take && cycles_next == 2'h2 |=> !instr_ready_reg [*4] ##1 instr_ready_reg)
    else $error("Two-cycle instruction does not hold for one period");

  a_indirect_extra: assert property (
    take && indirect_next |=> indirect_reg
    && cycles_reg == 2'h2 + {1'b0, $past(skip_next || pc_write)})
    else $error("Indirect access cycle not added");

  a_dest_select: assert property (
    take && byte_op |=> dec_reg.dest_file == $past(instr_word[DEST_POS]))
    else $error("Destination bit not honoured");

  a_bit_test_fields: assert property (
    take && instr_word[OPC_HI:11] == 3'h3 |=> dec_reg.bit_sel == $past(instr_word[9:7])
    && dec_reg.file_addr == $past(instr_word[6:0]) && !dec_reg.dest_file)
    else $error("Bit test fields decoded wrongly");

  a_single_cycle_ready: assert property (
    take && cycles_next == 2'h1 |=> instr_ready_reg)
    else $error("Single-cycle instruction left the decoder busy");

  a_three_cycle_busy: assert property (
    take && cycles_next == 2'h3 |=> !instr_ready_reg [*8] ##1 instr_ready_reg)
    else $error("Three-cycle instruction does not hold for two periods");

  a_dec_pulse_once: assert property (
    dec_valid_reg |=> !dec_valid_reg)
    else $error("Decode valid lasted more than one cycle");

endmodule : mcuid_decoder
`default_nettype wire

// file: mcuid_prog_mem.sv
// Program memory model offering instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module mcuid_prog_mem
  import mcuid_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ready,
  input  wire logic              strobe,
  output var  logic [WORD_W-1:0] instr_word,
  output var  logic              instr_valid,
  output var  logic              file_bit_value
);
  initial begin
    instr_word     = '0;
    instr_valid    = 1'b0;
    file_bit_value = 1'b0;
  end

  // Holds the word until the taking edge, then scrambles the lines
  task automatic fetch(input logic [WORD_W-1:0] w, input logic b, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    instr_word     <= w;
    instr_valid    <= 1'b1;
    file_bit_value <= b;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      ok = ready && strobe;
    end
    instr_valid    <= 1'b0;
    instr_word     <= ~w;
    file_bit_value <= ~b;
  endtask : fetch
endmodule : mcuid_prog_mem
`default_nettype wire

// file: mcuid_decoder_tb.sv
// Self-checking bench for the instruction decoder with a reference model
`timescale 1ns/1ps
`default_nettype none
module mcuid_decoder_tb import mcuid_pkg::*;;
  logic              clk;
  logic              nrst;
  logic [WORD_W-1:0] instr_word;
  logic              instr_valid;
  logic              file_bit_value;
  logic              instr_ready_reg;
  logic              dec_valid_reg;
  mcuid_dec_t        dec_reg;
  logic [1:0]        cycles_reg;
  logic              skip_reg;
  logic              indirect_reg;
  logic [1:0]        phase_reg;
  logic              period_strobe_reg;
  logic [3:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata_reg;
  int                miscompares;
  int                n_checks;
  int                seed;
  int                cyc;
  int                last_take;
  int                last_strobe;
  int                prev_cycles;
  logic [1:0]        sel_msb;
  logic [WORD_W-1:0] w;
  logic              b;
  logic              ok;

  mcuid_decoder mcuid_decoder_i (.clk(clk), .nrst(nrst), .instr_word(instr_word),
    .instr_valid(instr_valid), .file_bit_value(file_bit_value),
    .instr_ready_reg(instr_ready_reg), .dec_valid_reg(dec_valid_reg), .dec_reg(dec_reg),
    .cycles_reg(cycles_reg), .skip_reg(skip_reg), .indirect_reg(indirect_reg),
    .phase_reg(phase_reg), .period_strobe_reg(period_strobe_reg), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg));

  mcuid_prog_mem mcuid_prog_mem_i (.clk(clk), .ready(instr_ready_reg),
    .strobe(period_strobe_reg), .instr_word(instr_word), .instr_valid(instr_valid),
    .file_bit_value(file_bit_value));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  always @(posedge clk) begin
    if (nrst && period_strobe_reg === 1'b1) begin
      if (last_strobe > 0) chk("strobe spacing", QUARTER_COUNT, cyc - last_strobe);
      chk("phase at strobe", PHASE_LAST, phase_reg);
      last_strobe <= cyc;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    last_take = 0;
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
    last_take = 0;
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("register read", exp, reg_rdata_reg);
  endtask : reg_check

  // Reference decode, then offer the word and compare every result
  task automatic issue(input logic [WORD_W-1:0] wd, input logic bv);
    mcuid_op_t  op;
    logic [2:0] fl;
    logic       byt;
    logic       bop;
    logic       gotw;
    int         sk;
    int         ind;
    int         pcw;
    int         n;
    int         t;
    op = OP_NONE;
    fl = 3'h0;
    case (wd[13:8])
      OPC_ADD_WITH_CARRY: begin op = ADD_WITH_CARRY_OP; fl = 3'h7; end
      OPC_ARITH_SHR: begin op = ARITH_SHIFT_RIGHT_OP; fl = 3'h5; end
      OPC_OR_REG_FILE: begin op = OR_REG_WITH_FILE_OP; fl = 3'h1; end
      OPC_ROT_LEFT: begin op = ROTATE_LEFT_CARRY_OP; fl = 3'h4; end
      OPC_ROT_RIGHT: begin op = ROTATE_RIGHT_CARRY_OP; fl = 3'h4; end
      OPC_OR_LITERAL: begin op = OR_LITERAL_OP; fl = 3'h1; end
      OPC_XOR_LITERAL: begin op = XOR_LITERAL_OP; fl = 3'h1; end
      OPC_SUB_LITERAL: begin op = SUBTRACT_FROM_LITERAL_OP; fl = 3'h7; end
      OPC_LOAD_PCH: if (wd[7]) op = LOAD_PC_HIGH_LATCH_OP;
      default: begin
        if (wd[13:10] == OPC_SKIP_CLEAR) op = TEST_BIT_SKIP_CLEAR_OP;
        if (wd[13:10] == OPC_SKIP_SET) op = TEST_BIT_SKIP_SET_OP;
      end
    endcase
    byt = op inside {[ADD_WITH_CARRY_OP:ROTATE_RIGHT_CARRY_OP]};
    bop = op inside {TEST_BIT_SKIP_CLEAR_OP, TEST_BIT_SKIP_SET_OP};
    sk  = (op == TEST_BIT_SKIP_CLEAR_OP && !bv) || (op == TEST_BIT_SKIP_SET_OP && bv);
    ind = (byt || bop) && wd[6:1] == 6'h00 && sel_msb[wd[0]];
    pcw = byt && wd[7] && wd[6:0] == PCL_ADDR;
    n   = 1 + sk + ind + pcw;
    mcuid_prog_mem_i.fetch(wd, bv, gotw);
    t = cyc;
    if (!gotw) begin
      miscompares++;
      complete_run();
    end else begin
      if (last_take > 0) chk("take spacing", 4 * prev_cycles, t - last_take);
      #1 chk("dec valid", 1, dec_valid_reg);
      chk("op", op, dec_reg.op);
      chk("flags", fl, {dec_reg.upd_carry, dec_reg.upd_digit_carry, dec_reg.upd_zero});
      chk("cycles", n, cycles_reg);
      chk("skip", sk, skip_reg);
      chk("indirect", ind, indirect_reg);
      chk("ready", n == 1, instr_ready_reg);
      chk("dest", byt && wd[7], dec_reg.dest_file);
      if (byt || bop) chk("file addr", wd[6:0], dec_reg.file_addr);
      if (bop) chk("bit select", wd[9:7], dec_reg.bit_sel);
      if (op == LOAD_PC_HIGH_LATCH_OP) chk("literal", {1'b0, wd[6:0]}, dec_reg.literal);
      else if (fl != 3'h0 && !byt) chk("literal", wd[7:0], dec_reg.literal);
      @(posedge clk);
      #1 chk("dec pulse", 0, dec_valid_reg);
      prev_cycles = n;
      last_take   = t;
    end
  endtask : issue

  initial begin
    seed = 32'h256b;
    miscompares = 0;
    n_checks = 0;
    cyc = 0;
    last_take = 0;
    last_strobe = 0;
    prev_cycles = 1;
    sel_msb = 2'h0;
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge clk);
    #1 chk("reset ready", 1, instr_ready_reg);
    chk("reset phase", 0, {period_strobe_reg, phase_reg, dec_valid_reg});
    @(posedge clk);
    nrst <= 1'b1;
    reg_check(CTRL_OFS, CTRL_RST);
    reg_check(FSRMSB_OFS, {6'h00, FSRMSB_RST});
    reg_check(4'h9, 8'h00);
    reg_write(STATUS_OFS, 8'hff);
    reg_check(STATUS_OFS, 8'h00);
    for (int i = 0; i < 240; i++) begin
      w = WORD_W'($random(seed));
      b = 1'($random(seed));
      case (i % 12)
        0: w[13:8] = OPC_ADD_WITH_CARRY;
        1: w[13:8] = OPC_ARITH_SHR;
        2: w[13:8] = OPC_OR_REG_FILE;
        3: w[13:8] = OPC_ROT_LEFT;
        4: w[13:8] = OPC_ROT_RIGHT;
        5: w[13:10] = OPC_SKIP_CLEAR;
        6: w[13:10] = OPC_SKIP_SET;
        7: w[13:8] = OPC_OR_LITERAL;
        8: w[13:8] = OPC_XOR_LITERAL;
        9: w[13:8] = OPC_LOAD_PCH;
        10: w[13:8] = OPC_SUB_LITERAL;
        default: ;
      endcase
      if (i % 3 == 0) w[6:0] = 7'(i % 9 / 3);
      if (i % 20 == 19) begin
        sel_msb = 2'($random(seed));
        reg_write(FSRMSB_OFS, {6'h00, sel_msb});
      end
      issue(w, b);
    end
    sel_msb = 2'h3;
    reg_write(FSRMSB_OFS, 8'h03);
    reg_check(FSRMSB_OFS, 8'h03);
    issue({OPC_SKIP_SET, 3'h5, IND0_ADDR}, 1'b1);
    repeat (12) @(posedge clk);
    reg_check(STATUS_OFS, 8'h1e);
    reg_check(LASTOP_OFS, 8'(TEST_BIT_SKIP_SET_OP));
    reg_write(CTRL_OFS, 8'h00);
    reg_check(CTRL_OFS, 8'h00);
    mcuid_prog_mem_i.fetch({OPC_OR_LITERAL, 8'h5a}, 1'b0, ok);
    #1 chk("refused decode", 0, dec_valid_reg);
    chk("refused offer", 1, ok);
    chk("refused op", TEST_BIT_SKIP_SET_OP, dec_reg.op);
    reg_write(CTRL_OFS, 8'h01);
    issue({OPC_ADD_WITH_CARRY, 1'b1, PCL_ADDR}, 1'b0);
    issue({OPC_OR_REG_FILE, 1'b0, IND1_ADDR}, 1'b0);
    complete_run();
  end
endmodule : mcuid_decoder_tb
`default_nettype wire
